// ---- counter_array_pkg.sv ----
// Shared constants for the counter array compare block
package counter_array_pkg;

	// ==========================================================
	// Array shape
	localparam int NUM_MOD = 5;
	localparam int WDT_MOD = 4;

	// ==========================================================
	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CMODE = 8'h00;
	localparam logic [7:0] OFS_CNT_LO = 8'h04;
	localparam logic [7:0] OFS_CNT_HI = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;
	// Module n sits in page (MOD_PAGE_FIRST + n), 16 bytes each
	localparam logic [3:0] MOD_PAGE_FIRST = 4'h2;
	localparam logic [1:0] SUB_MODE = 2'h0;
	localparam logic [1:0] SUB_CMP_LO = 2'h1;
	localparam logic [1:0] SUB_CMP_HI = 2'h2;

	// ==========================================================
	// Module mode register fields
	localparam int MODE_COMPARATOR_ENABLE_BIT = 6;
	localparam int MODE_MAT = 3;
	localparam int MODE_TOG = 2;
	localparam int MODE_PWM = 1;

	// ==========================================================
	// Counter mode register fields
	localparam int COUNTER_MODE_REGISTER_RUN = 0;
	localparam int COUNTER_MODE_REGISTER_CPS_LO = 1;
	localparam int COUNTER_MODE_REGISTER_RESET_ON_MATCH_ENABLE = 6;
	localparam logic [1:0] CPS_SLOW = 2'h0;
	localparam logic [1:0] CPS_FAST = 2'h1;

	// ==========================================================
	// Status layout, divider and reset values
	localparam int ST_WDT = 5;
	localparam int ST_W = 6;
	localparam logic [3:0] DIV_SLOW = 4'hC;
	localparam logic [3:0] DIV_FAST = 4'h4;
	localparam logic [3:0] DIV_FULL = 4'h1;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] LOW_WRAP = 8'hFF;

	// ==========================================================
	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_state_t;

endpackage

// ---- compare_unit.sv ----
// One compare module: mode, compare pair, pulse-width and match logic
`timescale 1ns/1ps
module compare_unit import counter_array_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register writes
	input wire logic wr_mode,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wbyte,
	// Shared time base
	input wire logic [15:0] cnt,
	input wire logic tick,
	input wire logic step,
	// State seen by software and the pin
	output logic [7:0] mode_q,
	output logic [7:0] cmp_lo_q,
	output logic [7:0] cmp_hi_q,
	output logic pin_q,
	output logic match_evt
);

	// ==========================================================
	// Decode
	logic pwm_on; // Pulse-width mode selected
	logic cmp_en_q; // Comparator live, off between pair writes
	logic wrap; // Low byte about to roll from 255 to 00

	assign pwm_on = mode_q[MODE_COMPARATOR_ENABLE_BIT] & mode_q[MODE_PWM];
	assign wrap = tick & (cnt[7:0] == LOW_WRAP);
	// Match only on the cycle the counter took a new value
	assign match_evt = step & cmp_en_q & mode_q[MODE_COMPARATOR_ENABLE_BIT] &
		mode_q[MODE_MAT] & ~pwm_on & (cnt == {cmp_hi_q, cmp_lo_q});

	// ==========================================================
	// Mode register
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mode_q <= BYTE_RST;
		end else if (wr_mode) begin
			mode_q <= wbyte;
		end
	end

	// Active low byte; duty reloads only at wrap so a period never tears
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmp_lo_q <= BYTE_RST;
		end else if (wr_lo) begin
			cmp_lo_q <= wbyte;
		end else if (pwm_on && wrap) begin
			cmp_lo_q <= cmp_hi_q; // [R4]
		end
	end

	// High byte holds the duty value or the upper compare half
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmp_hi_q <= BYTE_RST;
		end else if (wr_hi) begin
			cmp_hi_q <= wbyte;
		end
	end

	// Half-written pair must not match
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmp_en_q <= 1'b1;
		end else if (wr_hi) begin
			cmp_en_q <= 1'b1; // [R15]
		end else if (wr_lo) begin
			cmp_en_q <= 1'b0; // [R15]
		end
	end

	// Pin: level compare in pulse mode, otherwise toggle on match when the toggle bit is set
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pin_q <= 1'b0;
		end else if (pwm_on) begin
			pin_q <= (cnt[7:0] >= cmp_lo_q); // [R1] [R17]
		end else if (match_evt && mode_q[MODE_TOG]) begin
			pin_q <= ~pin_q;
		end
	end

	// ==========================================================
	// Checks
	a_pwm_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
		$past(pwm_on) && pwm_on |-> pin_q == ($past(cnt[7:0]) >= $past(cmp_lo_q)))
		else $error("pwm pin level wrong");
	a_duty_reload: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
		pwm_on && wrap && !wr_lo |=> cmp_lo_q == $past(cmp_hi_q))
		else $error("duty not reloaded at wrap");
	a_duty_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
		pwm_on && !wrap && !wr_lo |=> $stable(cmp_lo_q))
		else $error("duty changed mid period");
	a_cmp_suspend: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
		wr_lo && !wr_hi ##1 !wr_hi |-> !cmp_en_q && !match_evt)
		else $error("match while pair half written");
	a_cmp_resume: assert property (@(posedge sys_clk) disable iff (!nrst) // [R15]
		wr_hi |=> cmp_en_q)
		else $error("comparator not re-enabled");
	c_pwm_reload: cover property (@(posedge sys_clk) disable iff (!nrst)
		pwm_on && wrap && cmp_hi_q != cmp_lo_q);
	c_toggle: cover property (@(posedge sys_clk) disable iff (!nrst)
		match_evt && mode_q[MODE_TOG]);

endmodule

// ---- counter_array_pwm_watchdog.sv ----
// Counter array top: bus slave, shared counter, modules, watchdog, irq
//
// Notes on behaviour
// R1: pulse pin low below compare, else high
// R2: software sets pulse and comparator enable bits
// R3: one shared counter sets every output frequency
// R4: duty byte copied to compare at wrap
// R5: software computes duty as 256 times (1-duty)
// R6: only module 4 can act as watchdog
// R7: 16-bit match in watchdog mode raises reset
// R8: watchdog reset never drives external reset pin
// R9: software arms module 4 and enable bit
// R10: enable bit clear means no reset
// R11: software refreshes compare, not shared counter
// R12: software writes compare low before high
// R13: refresh writes 00 then counter high byte
// R14: refresh runs from main loop only
// R15: low write suspends, high write resumes matching
// R16: software also sets reset-output enable bit
// R17: pulse output on own pin, counter-synchronous
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module counter_array_pwm_watchdog import counter_array_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Module pins
	output logic [NUM_MOD-1:0] module_io_pin,
	// System outputs
	output logic internal_reset,
	output logic irq
);

	// ==========================================================
	// Bus slave
	bus_state_t bus_q; // Address or data phase
	logic [7:0] addr_q; // Latched byte offset
	logic write_q; // Latched direction
	logic accept; // Address phase taken this edge
	logic wr_en; // Write data present
	logic [7:0] wbyte; // Written byte, low lane
	logic [7:0] rd_byte; // Read mux result

	// Only NONSEQ/SEQ transfers start a data phase
	assign accept = hsel & htrans[1] & hready & (bus_q == BUS_IDLE);
	assign wr_en = (bus_q == BUS_DATA) & write_q;
	assign wbyte = hwdata[7:0];

	// Phase sequencer: one wait state lets reads see the last write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bus_q <= BUS_IDLE;
			hreadyout <= 1'b1;
		end else begin
			case (bus_q)
				BUS_IDLE: begin
					if (accept) begin
						bus_q <= BUS_DATA;
						hreadyout <= 1'b0;
					end
				end
				BUS_DATA: begin
					bus_q <= BUS_IDLE;
					hreadyout <= 1'b1;
				end
				default: begin
					bus_q <= BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// Address phase capture; upper address bits are not decoded
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			addr_q <= BYTE_RST;
			write_q <= 1'b0;
		end else if (accept) begin
			addr_q <= haddr[7:0];
			write_q <= hwrite;
		end
	end

	// Read data registered in the data phase, zero for unmapped
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_q == BUS_DATA) begin
			hrdata <= {24'h00_0000, write_q ? BYTE_RST : rd_byte};
		end
	end

	// Every transfer is answered OKAY
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Module page decode
	logic [3:0] mod_sel; // Module index from the page
	logic mod_hit; // Offset falls in a module page

	assign mod_sel = addr_q[7:4] - MOD_PAGE_FIRST;
	assign mod_hit = (addr_q[7:4] >= MOD_PAGE_FIRST) &&
		(mod_sel < 4'(NUM_MOD)) && (addr_q[1:0] == 2'h0) &&
		(addr_q[3:2] != 2'h3);

	// ==========================================================
	// Counter mode register
	logic [7:0] cmode_q; // Run, clock select, reset-on-match enable

	// Written whole; firmware read-modify-writes to set single bits
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmode_q <= BYTE_RST;
		end else if (wr_en && addr_q == OFS_CMODE) begin
			cmode_q <= wbyte;
		end
	end

	// ==========================================================
	// Prescaler
	logic [3:0] pre_q; // Cycles since last tick
	logic [3:0] div; // Selected divide ratio
	logic tick_q; // One-cycle counter enable

	// Clock source select
	always_comb begin
		case (cmode_q[COUNTER_MODE_REGISTER_CPS_LO +: 2])
			CPS_SLOW: div = DIV_SLOW;
			CPS_FAST: div = DIV_FAST;
			default: div = DIV_FULL;
		endcase
	end

	// Divider produces the enable pulse that paces the counter
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pre_q <= 4'h0;
			tick_q <= 1'b0;
		end else if (!cmode_q[COUNTER_MODE_REGISTER_RUN]) begin
			pre_q <= 4'h0;
			tick_q <= 1'b0;
		end else if (pre_q >= div - 4'h1) begin
			pre_q <= 4'h0;
			tick_q <= 1'b1;
		end else begin
			pre_q <= pre_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	// ==========================================================
	// Shared counter
	logic [15:0] cnt_q; // Single time base for all modules
	logic cnt_wr; // Software writes a counter byte
	logic step_q; // Counter took a new value last edge

	assign cnt_wr = wr_en &&
		(addr_q == OFS_CNT_LO || addr_q == OFS_CNT_HI);

	// Software write wins over a tick in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cnt_q <= 16'h0000;
		end else if (wr_en && addr_q == OFS_CNT_LO) begin
			cnt_q[7:0] <= wbyte;
		end else if (wr_en && addr_q == OFS_CNT_HI) begin
			cnt_q[15:8] <= wbyte;
		end else if (tick_q) begin
			cnt_q <= cnt_q + 16'h0001; // [R3]
		end
	end

	// Matches are judged once per counter value, not per cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			step_q <= 1'b0;
		end else begin
			step_q <= tick_q && !cnt_wr;
		end
	end

	// ==========================================================
	// Compare modules
	logic [7:0] mode_a [NUM_MOD]; // Mode registers
	logic [7:0] lo_a [NUM_MOD]; // Compare low bytes
	logic [7:0] hi_a [NUM_MOD]; // Compare high bytes
	logic [NUM_MOD-1:0] match_evt; // Per-module match pulses

	// Every module sees the same counter, tick and step
	for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
		logic sel; // This module's page addressed for write
		assign sel = wr_en & mod_hit & (mod_sel == 4'(g));
		compare_unit u_cmp (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.wr_mode(sel & (addr_q[3:2] == SUB_MODE)),
			.wr_lo(sel & (addr_q[3:2] == SUB_CMP_LO)),
			.wr_hi(sel & (addr_q[3:2] == SUB_CMP_HI)),
			.wbyte(wbyte),
			.cnt(cnt_q), // [R3]
			.tick(tick_q & ~cnt_wr), // [R4]
			.step(step_q),
			.mode_q(mode_a[g]),
			.cmp_lo_q(lo_a[g]),
			.cmp_hi_q(hi_a[g]),
			.pin_q(module_io_pin[g]), // [R17]
			.match_evt(match_evt[g])
		);
	end

	// ==========================================================
	// Watchdog
	logic wdt_fire; // Module 4 matched while armed

	// Only the last module is wired to reset; it keeps all other modes
	assign wdt_fire = match_evt[WDT_MOD] & cmode_q[COUNTER_MODE_REGISTER_RESET_ON_MATCH_ENABLE]; // [R6] [R10]

	// Reset request is internal only; no external reset pin exists
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			internal_reset <= 1'b0;
		end else begin
			internal_reset <= wdt_fire; // [R7] [R8]
		end
	end

	// ==========================================================
	// Interrupts
	logic [ST_W-1:0] status_q; // Sticky events
	logic [ST_W-1:0] mask_q; // Enables onto irq
	logic [ST_W-1:0] st_set; // Events this cycle
	logic [ST_W-1:0] st_clr; // Write-one-to-clear

	assign st_set = {wdt_fire, match_evt};
	assign st_clr = (wr_en && addr_q == OFS_STATUS) ?
		wbyte[ST_W-1:0] : {ST_W{1'b0}};

	// A new event beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status_q <= {ST_W{1'b0}};
		end else begin
			status_q <= (status_q & ~st_clr) | st_set;
		end
	end

	// Mask register
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mask_q <= {ST_W{1'b0}};
		end else if (wr_en && addr_q == OFS_MASK) begin
			mask_q <= wbyte[ST_W-1:0];
		end
	end

	// Level interrupt
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	// ==========================================================
	// Read mux
	always_comb begin
		rd_byte = BYTE_RST;
		case (addr_q)
			OFS_CMODE: rd_byte = cmode_q;
			OFS_CNT_LO: rd_byte = cnt_q[7:0];
			OFS_CNT_HI: rd_byte = cnt_q[15:8];
			OFS_STATUS: rd_byte = {{(8-ST_W){1'b0}}, status_q};
			OFS_MASK: rd_byte = {{(8-ST_W){1'b0}}, mask_q};
			default: rd_byte = BYTE_RST;
		endcase
		// Module pages
		for (int i = 0; i < NUM_MOD; i++) begin
			if (mod_hit && mod_sel == 4'(i)) begin
				case (addr_q[3:2])
					SUB_MODE: rd_byte = mode_a[i];
					SUB_CMP_LO: rd_byte = lo_a[i];
					SUB_CMP_HI: rd_byte = hi_a[i];
					default: rd_byte = BYTE_RST;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	a_count_step: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
		tick_q && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not advance on tick");
	a_count_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
		!tick_q && !cnt_wr |=> $stable(cnt_q))
		else $error("counter moved without tick");
	a_wdt_reset: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
		match_evt[WDT_MOD] && cmode_q[COUNTER_MODE_REGISTER_RESET_ON_MATCH_ENABLE] |=> internal_reset)
		else $error("watchdog match gave no reset");
	a_wdt_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
		!cmode_q[COUNTER_MODE_REGISTER_RESET_ON_MATCH_ENABLE] |=> !internal_reset)
		else $error("reset while watchdog disabled");
	a_wdt_only4: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
		internal_reset |-> $past(match_evt[WDT_MOD]))
		else $error("reset without module 4 match");
	a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
		internal_reset |=> !internal_reset)
		else $error("internal reset held too long");
	// Bus timing: exactly one wait state per transfer
	a_bus_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
		accept |=> !hreadyout && bus_q == BUS_DATA)
		else $error("no wait state after address phase");
	a_bus_ready: assert property (@(posedge sys_clk) disable iff (!nrst)
		!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	// Sticky events survive a clear written in the same cycle
	a_status_set: assert property (@(posedge sys_clk) disable iff (!nrst)
		|st_set |=> (status_q & $past(st_set)) == $past(st_set))
		else $error("event lost against clear");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
		irq == $past(|(status_q & mask_q)))
		else $error("irq does not follow masked status");
	a_step_tick: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
		step_q |-> $past(tick_q) && !$past(cnt_wr))
		else $error("match step without counter tick");
	c_wdt_fire: cover property (@(posedge sys_clk) disable iff (!nrst)
		internal_reset);
	c_irq: cover property (@(posedge sys_clk) disable iff (!nrst)
		$rose(irq));

endmodule

// ---- counter_array_pwm_watchdog_tb.sv ----
// Self-checking bench for the counter array pulse and watchdog block
`timescale 1ns/1ps
module counter_array_pwm_watchdog_tb import counter_array_pkg::*;;

	// ==========================================================
	// Compare helper
	// Case equality so an unknown never passes as a match
	`define chk(what, exp, got) \
		begin \
			cmp_count++; \
			if ((got) !== (exp)) begin \
				errors++; \
				$display("unexpected %s exp %h got %h", what, exp, got); \
			end \
		end

	// ==========================================================
	// Bench signals
	logic sys_clk; // 125 MHz system clock
	logic nrst; // Synchronous reset, low active
	logic hsel; // Slave select
	logic [31:0] haddr; // Bus address
	logic [1:0] htrans; // Transfer kind
	logic hwrite; // Write strobe
	logic [2:0] hsize; // Always a word
	logic [31:0] hwdata; // Write data
	logic hreadyout; // Slave ready, fed back as hready
	logic [31:0] hrdata; // Read data
	logic hresp; // Response, always OKAY
	logic [NUM_MOD-1:0] module_io_pin; // Module pins
	logic internal_reset; // Watchdog reset pulse
	logic irq; // Level interrupt
	int errors; // Mismatch count
	int cmp_count; // Comparison count
	int hits; // Reset pulses seen in a window
	logic [31:0] rd; // Last read value
	logic [7:0] cl_tab [4]; // Counter low bytes to try
	logic pin_tab [4]; // Expected pin level for each

	// ==========================================================
	// Design under test
	counter_array_pwm_watchdog DUT (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.module_io_pin(module_io_pin),
		.internal_reset(internal_reset),
		.irq(irq)
	);

	// ==========================================================
	// Clock
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	// ==========================================================
	// Bus tasks
	// Single word transfer; waits on the slave, never on a fixed count
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		`chk("hresp", 1'b0, hresp)
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, {24'h0, d}, q);
	endtask

	task automatic rd_chk(input string what, input logic [31:0] a,
		input logic [7:0] exp);
		xfer(a, 1'b0, 32'h0, rd);
		`chk(what, {24'h0, exp}, rd)
	endtask

	// Byte address of a field of module n
	function automatic logic [31:0] maddr(input int n, input int sub);
		return 32'h20 + 32'h10 * n + 32'h4 * sub;
	endfunction

	// Counts watchdog pulses over a window of cycles
	task automatic watch_rst(input int n);
		hits = 0;
		repeat (n) begin
			@(posedge sys_clk);
			if (internal_reset === 1'b1) begin
				hits++;
			end
		end
	endtask

	// ==========================================================
	// Verdict
	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog on the run; the sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		errors = 0;
		cmp_count = 0;
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cl_tab = '{8'h3F, 8'h40, 8'hFF, 8'h00};
		pin_tab = '{1'b0, 1'b1, 1'b1, 1'b0};
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		// Reset state and an unmapped read
		rd_chk("status", 32'h0C, 8'h00);
		rd_chk("unmapped", 32'h7C, 8'h00);
		`chk("irq", 1'b0, irq)
		// Pulse mode on module 0, counter stopped
		wr(maddr(0, 0), 8'h42);
		wr(maddr(0, 2), 8'h40);
		rd_chk("cmp_lo early", maddr(0, 1), 8'h00);
		// Run briefly across a low byte wrap
		wr(32'h04, 8'hFE);
		wr(32'h00, 8'h05);
		wr(32'h00, 8'h00);
		rd_chk("cmp_lo loaded", maddr(0, 1), 8'h40);
		rd_chk("cnt_hi carry", 32'h08, 8'h01);
		// Pin level against boundary counts
		for (int i = 0; i < 4; i++) begin
			wr(32'h04, cl_tab[i]);
			repeat (3) @(posedge sys_clk);
			`chk("pwm pin", pin_tab[i], module_io_pin[0])
			`chk("idle pins", 4'h0, module_io_pin[4:1])
		end
		// Watchdog: low write alone keeps matching off
		wr(maddr(4, 0), 8'h4C);
		wr(32'h04, 8'h34);
		wr(32'h08, 8'h12);
		wr(maddr(4, 1), 8'h35);
		wr(32'h00, 8'h45);
		watch_rst(20);
		`chk("suspended", 0, hits)
		wr(32'h00, 8'h00);
		// High write resumes, but enable bit clear
		wr(maddr(4, 2), 8'h12);
		wr(32'h04, 8'h34);
		wr(32'h00, 8'h05);
		watch_rst(20);
		`chk("no enable", 0, hits)
		wr(32'h00, 8'h00);
		rd_chk("match only", 32'h0C, 8'h10);
		`chk("toggle pin", 1'b1, module_io_pin[4])
		wr(32'h0C, 8'h3F);
		rd_chk("cleared", 32'h0C, 8'h00);
		// Armed: exactly one single-cycle reset pulse
		wr(32'h04, 8'h34);
		wr(32'h00, 8'h45);
		watch_rst(40);
		`chk("reset pulses", 1, hits)
		wr(32'h00, 8'h00);
		rd_chk("wdt status", 32'h0C, 8'h30);
		// Interrupt masked, unmasked, then cleared
		`chk("irq masked", 1'b0, irq)
		wr(32'h10, 8'h20);
		repeat (2) @(posedge sys_clk);
		`chk("irq raised", 1'b1, irq)
		rd_chk("mask", 32'h10, 8'h20);
		wr(32'h0C, 8'h20);
		repeat (2) @(posedge sys_clk);
		`chk("irq cleared", 1'b0, irq)
		rd_chk("status left", 32'h0C, 8'h10);
		// Armed watchdog kept quiet by main-loop compare refresh
		wr(32'h04, 8'h30);
		wr(32'h00, 8'h45);
		repeat (2) begin
			wr(maddr(4, 1), 8'h00);
			xfer(32'h08, 1'b0, 32'h0, rd);
			wr(maddr(4, 2), rd[7:0]);
		end
		watch_rst(20);
		wr(32'h00, 8'h00);
		`chk("refreshed", 0, hits)
		rd_chk("refresh status", 32'h0C, 8'h10);
		// Module 4 still usable for pulse mode
		wr(maddr(4, 0), 8'h42);
		wr(maddr(4, 2), 8'h80);
		wr(32'h04, 8'hFE);
		wr(32'h00, 8'h05);
		wr(32'h00, 8'h00);
		wr(32'h04, 8'h90);
		repeat (3) @(posedge sys_clk);
		`chk("mod4 pwm", 1'b1, module_io_pin[4])
		wr(32'h04, 8'h7F);
		repeat (3) @(posedge sys_clk);
		`chk("mod4 pwm low", 1'b0, module_io_pin[4])
		// Mid-run reset clears pins, status and compare bytes
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		`chk("pins at reset", 5'h00, module_io_pin)
		`chk("irq at reset", 1'b0, irq)
		rd_chk("status at reset", 32'h0C, 8'h00);
		rd_chk("lo at reset", maddr(4, 1), 8'h00);
		// Slower clock sources, one 24-cycle run each
		wr(32'h00, 8'h01);
		repeat (20) @(posedge sys_clk);
		wr(32'h00, 8'h00);
		rd_chk("slow count", 32'h04, 8'h02);
		wr(32'h04, 8'h00);
		wr(32'h00, 8'h03);
		repeat (20) @(posedge sys_clk);
		wr(32'h00, 8'h00);
		rd_chk("fast count", 32'h04, 8'h06);
		close_out();
	end

endmodule
